// ### hdl/sfrbk_bank.sv
// SFR slice: summation upper bytes, offset trim, supply monitor,
// extended interrupt enable, product codes, flash control and timing,
// secondary accumulator and peripheral power-down.
// Assumes a single-cycle SFR bus from the core on sys_clk.
//
// Behaviour
// - Third summation byte reads and writes accumulator bits 16-23, resets zero.
// - Fourth summation byte is accumulator bits 24-31, resets zero.
// - Trim value zero or only sign bit set disables the offset.
// - Trim top bit is sign, low seven bits magnitude over 127.
// - Analog detect disable bit: zero enables, one disables the analog detector.
// - Three-bit analog threshold; all-ones compares analog input seven instead.
// - Digital detect disable bit: zero enables, one disables the digital detector.
// - Low three bits pick digital threshold; all-ones compares analog input six.
// - Interrupt enable resets upper bits set; watchdog enable gates watchdog request.
// - Low four enable bits gate external interrupts five down to two.
// - Low product code read-only; two low bits give flash size code.
// - High product code read-only fixed byte; writes ignored.
// - Page erase bit writable in user and programming modes.
// - Flash delay line select: zero bypass (default), one delay line.
// - Busy reads one during flash write or erase, else zero.
// - Read-only mode bits: programming flag, serial flag valid with it.
// - Erase pulse is (1+upper nibble)*(1+ms divider) clock periods.
// - Write pulse is (1+lower nibble)*(1+us divider)*5 clock periods.
// - Secondary accumulator is an operand store, resets zero.
// - Seven power-down bits, one powers module down; all down at reset.
// - Converter power-down also powers reference and summation registers down.
// - Two-wire and SPI power-down must not both be cleared; the bank stores both bits as written and does not stop it.
// - Millisecond divider period is sixteen-bit value plus one clocks.
// - Microsecond divider divides clock by six-bit value plus one.
`timescale 1ns/1ps
`include "sfrbk_defines.svh"
module sfrbk_bank import sfrbk_pkg::*; #(
  parameter logic [1:0] FLASH_SIZE_CODE = 2'b11,
  parameter logic [7:0] PRODUCT_HIGH = 8'h5a, // Arbitrary value
  parameter logic [7:0] VERSION_CODE = 8'h3c, // Arbitrary value
  parameter int MS_DIV_WIDTH = 16,
  parameter int US_DIV_WIDTH = 6
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [MS_DIV_WIDTH-1:0] millisecond_divider,
  input wire logic [US_DIV_WIDTH-1:0] microsecond_divider,
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire logic prog_mode_in,
  input wire logic serial_prog_in,
  input wire logic sum_load,
  input wire logic [15:0] sum_upper_in,
  output logic [15:0] sum_upper,
  input wire logic watchdog_irq_req,
  input wire logic [3:0] ext_irq_req,
  output logic watchdog_irq,
  output logic [3:0] ext_irq,
  output logic offset_enable,
  output logic offset_negative,
  output logic [6:0] offset_magnitude,
  output sfrbk_supply_t supply_ctrl,
  output sfrbk_power_t power_ctrl,
  output logic page_erase_mode,
  output logic flash_delay_line_sel,
  output logic flash_pulse,
  output logic flash_busy,
  output logic [7:0] secondary_accumulator
);
  initial begin
    if (MS_DIV_WIDTH != 16) $error("sfrbk_bank: millisecond divider must be 16 bits");
    if (US_DIV_WIDTH != 6) $error("sfrbk_bank: microsecond divider must be 6 bits");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] sum2_reg;
  logic [7:0] sum3_reg;
  logic [7:0] trim_reg;
  logic [7:0] smon_reg;
  logic [4:0] ien_reg;
  logic page_erase_reg;
  logic dly_reg;
  logic [7:0] ftim_reg;
  logic [7:0] accb_reg;
  logic [6:0] pdn_reg;
  logic mode_prog_reg;
  logic mode_serial_reg;
  sfrbk_fl_state_t fl_state_reg;
  logic fl_erase_reg;
  logic [3:0] fl_outer_reg;
  logic [2:0] fl_five_reg;
  logic ms_tick;
  logic us_tick;
  logic fl_clear;

  logic wr_sum2, wr_sum3, wr_trim, wr_smon, wr_ien, wr_fctl, wr_ftim, wr_accb, wr_pdn;
  assign wr_sum2 = sfr_wr && (sfr_addr == `SFRBK_SUM2_OFS);
  assign wr_sum3 = sfr_wr && (sfr_addr == `SFRBK_SUM3_OFS);
  assign wr_trim = sfr_wr && (sfr_addr == `SFRBK_TRIM_OFS);
  assign wr_smon = sfr_wr && (sfr_addr == `SFRBK_SMON_OFS);
  assign wr_ien = sfr_wr && (sfr_addr == `SFRBK_IEN_OFS);
  assign wr_fctl = sfr_wr && (sfr_addr == `SFRBK_FCTL_OFS);
  assign wr_ftim = sfr_wr && (sfr_addr == `SFRBK_FTIM_OFS);
  assign wr_accb = sfr_wr && (sfr_addr == `SFRBK_ACCB_OFS);
  assign wr_pdn = sfr_wr && (sfr_addr == `SFRBK_PDN_OFS);

  // ----------------------------------------
  // Summation upper bytes
  // ----------------------------------------
  // CPU write wins over arithmetic load; held at zero while converter is down
  always_ff @(posedge sys_clk) begin
    if (srst || pdn_reg[3]) begin
      sum2_reg <= `SFRBK_SUM_RST;
      sum3_reg <= `SFRBK_SUM_RST;
    end else begin
      if (wr_sum2) begin
        sum2_reg <= sfr_wdata;
      end else if (sum_load) begin
        sum2_reg <= sum_upper_in[7:0];
      end
      if (wr_sum3) begin
        sum3_reg <= sfr_wdata;
      end else if (sum_load) begin
        sum3_reg <= sum_upper_in[15:8];
      end
    end
  end

  // ----------------------------------------
  // Plain read/write registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trim_reg <= `SFRBK_TRIM_RST;
      smon_reg <= `SFRBK_SMON_RST;
      ftim_reg <= `SFRBK_FTIM_RST;
      accb_reg <= `SFRBK_ACCB_RST;
      pdn_reg <= 7'(`SFRBK_PDN_RST);
    end else begin
      if (wr_trim) trim_reg <= sfr_wdata;
      if (wr_smon) smon_reg <= sfr_wdata;
      if (wr_ftim) ftim_reg <= sfr_wdata;
      if (wr_accb) accb_reg <= sfr_wdata;
      // Software keeps one of two-wire and SPI down; the bits are stored as written
      if (wr_pdn) pdn_reg <= sfr_wdata[6:0];
    end
  end

  // Interrupt enables: only the five live bits are stored
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ien_reg <= 5'(`SFRBK_IEN_RST);
    end else if (wr_ien) begin
      ien_reg <= sfr_wdata[4:0];
    end
  end

  // Flash control: page erase and delay-line bits; mode flags sampled
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      page_erase_reg <= 1'b0;
      dly_reg <= 1'b0;
      mode_prog_reg <= 1'b0;
      mode_serial_reg <= 1'b1;
    end else begin
      // Writable regardless of the programming mode
      if (wr_fctl) begin
        page_erase_reg <= sfr_wdata[`SFRBK_FCTL_PAGE_ERASE_BIT];
        dly_reg <= sfr_wdata[`SFRBK_FCTL_DLY_BIT];
      end
      mode_prog_reg <= prog_mode_in;
      mode_serial_reg <= serial_prog_in;
    end
  end

  // ----------------------------------------
  // Flash pulse timer
  // ----------------------------------------
  // Dividers restart at each pulse so the length is exact
  assign fl_clear = (fl_state_reg != SFRBK_FL_RUN);

  sfrbk_divider #(.WIDTH(MS_DIV_WIDTH)) u_ms_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .clear(fl_clear),
    .div(millisecond_divider),
    .tick(ms_tick)
  );

  sfrbk_divider #(.WIDTH(US_DIV_WIDTH)) u_us_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .clear(fl_clear),
    .div(microsecond_divider),
    .tick(us_tick)
  );

  // Erase: (1+nibble) ms ticks; write: (1+nibble) groups of five us ticks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fl_state_reg <= SFRBK_FL_IDLE;
      fl_erase_reg <= 1'b0;
      fl_outer_reg <= 4'h0;
      fl_five_reg <= 3'h0;
    end else begin
      case (fl_state_reg)
        SFRBK_FL_IDLE: begin
          if (flash_erase_start || flash_write_start) begin
            fl_state_reg <= SFRBK_FL_RUN;
            fl_erase_reg <= flash_erase_start;
            fl_outer_reg <= flash_erase_start ? ftim_reg[7:4] : ftim_reg[3:0];
            fl_five_reg <= 3'h0;
          end
        end
        SFRBK_FL_RUN: begin
          if (fl_erase_reg) begin
            if (ms_tick) begin
              if (fl_outer_reg == 4'h0) fl_state_reg <= SFRBK_FL_DONE;
              else fl_outer_reg <= fl_outer_reg - 4'h1;
            end
          end else if (us_tick) begin
            if (fl_five_reg == 3'(`SFRBK_WRITE_MULT - 1)) begin
              fl_five_reg <= 3'h0;
              if (fl_outer_reg == 4'h0) fl_state_reg <= SFRBK_FL_DONE;
              else fl_outer_reg <= fl_outer_reg - 4'h1;
            end else begin
              fl_five_reg <= fl_five_reg + 3'h1;
            end
          end
        end
        SFRBK_FL_DONE: begin
          fl_state_reg <= SFRBK_FL_IDLE;
        end
        default: begin
          fl_state_reg <= SFRBK_FL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      offset_enable <= 1'b0;
      offset_negative <= 1'b0;
      offset_magnitude <= 7'h00;
      supply_ctrl <= '0;
      power_ctrl <= '1;
      page_erase_mode <= 1'b0;
      flash_delay_line_sel <= 1'b0;
      flash_pulse <= 1'b0;
      flash_busy <= 1'b0;
      secondary_accumulator <= 8'h00;
      sum_upper <= 16'h0000;
    end else begin
      offset_enable <= (trim_reg[6:0] != 7'h00);
      offset_negative <= trim_reg[7];
      offset_magnitude <= trim_reg[6:0];
      supply_ctrl.analog_enable <= !smon_reg[7];
      supply_ctrl.analog_threshold_sel <= smon_reg[6:4];
      supply_ctrl.analog_use_input_seven <= &smon_reg[6:4];
      supply_ctrl.digital_enable <= !smon_reg[3];
      supply_ctrl.digital_threshold_sel <= smon_reg[2:0];
      supply_ctrl.digital_use_input_six <= &smon_reg[2:0];
      power_ctrl <= sfrbk_power_t'(pdn_reg);
      page_erase_mode <= page_erase_reg;
      flash_delay_line_sel <= dly_reg;
      flash_pulse <= (fl_state_reg == SFRBK_FL_RUN);
      flash_busy <= (fl_state_reg != SFRBK_FL_IDLE);
      secondary_accumulator <= accb_reg;
      sum_upper <= {sum3_reg, sum2_reg};
    end
  end

  // Interrupt gating, one cycle behind the request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      watchdog_irq <= 1'b0;
      ext_irq <= 4'h0;
    end else begin
      watchdog_irq <= watchdog_irq_req && ien_reg[4];
      ext_irq <= ext_irq_req & ien_reg[3:0];
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Data is registered; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `SFRBK_SUM2_OFS) sfr_rdata <= sum2_reg;
      else if (sfr_addr == `SFRBK_SUM3_OFS) sfr_rdata <= sum3_reg;
      else if (sfr_addr == `SFRBK_TRIM_OFS) sfr_rdata <= trim_reg;
      else if (sfr_addr == `SFRBK_SMON_OFS) sfr_rdata <= smon_reg;
      else if (sfr_addr == `SFRBK_IEN_OFS) sfr_rdata <= `SFRBK_IEN_FIXED | {3'h0, ien_reg};
      else if (sfr_addr == `SFRBK_PCL_OFS) sfr_rdata <= {`SFRBK_PCL_FIXED, FLASH_SIZE_CODE};
      else if (sfr_addr == `SFRBK_PCH_OFS) sfr_rdata <= PRODUCT_HIGH;
      else if (sfr_addr == `SFRBK_VER_OFS) sfr_rdata <= VERSION_CODE;
      else if (sfr_addr == `SFRBK_FCTL_OFS) begin
        sfr_rdata <= {1'b0, page_erase_reg, 1'b0, dly_reg, 1'b0,
                      (fl_state_reg != SFRBK_FL_IDLE),
                      mode_serial_reg && mode_prog_reg, mode_prog_reg};
      end
      else if (sfr_addr == `SFRBK_FTIM_OFS) sfr_rdata <= ftim_reg;
      else if (sfr_addr == `SFRBK_ACCB_OFS) sfr_rdata <= accb_reg;
      else if (sfr_addr == `SFRBK_PDN_OFS) sfr_rdata <= {1'b0, pdn_reg};
      else sfr_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_trim_off_zero: assert property (@(posedge sys_clk) disable iff (srst)
    ($past(trim_reg) == 8'h00 || $past(trim_reg) == `SFRBK_TRIM_NEG_ZERO) |-> !offset_enable)
    else $error("offset enabled with zero magnitude");

  a_analog_enable: assert property (@(posedge sys_clk) disable iff (srst)
    wr_smon ##2 1 |-> supply_ctrl.analog_enable == !$past(sfr_wdata[7], 2))
    else $error("analog enable does not follow disable bit");

  a_digital_enable: assert property (@(posedge sys_clk) disable iff (srst)
    wr_smon ##2 1 |-> supply_ctrl.digital_enable == !$past(sfr_wdata[3], 2))
    else $error("digital enable does not follow disable bit");

  a_wdog_gate: assert property (@(posedge sys_clk) disable iff (srst)
    !ien_reg[4] |=> !watchdog_irq)
    else $error("watchdog interrupt passed while disabled");

  a_ext_gate: assert property (@(posedge sys_clk) disable iff (srst)
    1 |=> ext_irq == ($past(ext_irq_req) & $past(ien_reg[3:0])))
    else $error("external interrupt gating wrong");

  a_ien_upper: assert property (@(posedge sys_clk) disable iff (srst)
    sfr_rd && sfr_addr == `SFRBK_IEN_OFS |=> sfr_rdata[7:5] == 3'h7)
    else $error("interrupt enable upper bits not one");

  a_pch_fixed: assert property (@(posedge sys_clk) disable iff (srst)
    sfr_rd && sfr_addr == `SFRBK_PCH_OFS |=> sfr_rdata == PRODUCT_HIGH)
    else $error("high product code changed");

  a_busy_flag: assert property (@(posedge sys_clk) disable iff (srst)
    fl_state_reg == SFRBK_FL_IDLE && (flash_erase_start || flash_write_start)
      |=> ##1 flash_busy)
    else $error("busy not raised after start");

  a_sum_powerdown: assert property (@(posedge sys_clk) disable iff (srst)
    pdn_reg[3] |=> sum2_reg == 8'h00 && sum3_reg == 8'h00)
    else $error("summation kept while converter down");
endmodule : sfrbk_bank

// ### hdl/sfrbk_defines.svh
// Offsets, field positions and reset values of the SFR slice.
// Assumes an 8-bit SFR address space, one byte per register.
`ifndef SFRBK_DEFINES_SVH
`define SFRBK_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SFRBK_SUM2_OFS 8'he4
`define SFRBK_SUM3_OFS 8'he5
`define SFRBK_TRIM_OFS 8'he6
`define SFRBK_SMON_OFS 8'he7
`define SFRBK_IEN_OFS 8'he8
`define SFRBK_PCL_OFS 8'he9
`define SFRBK_PCH_OFS 8'hea
`define SFRBK_VER_OFS 8'heb
`define SFRBK_FCTL_OFS 8'hee
`define SFRBK_FTIM_OFS 8'hef
`define SFRBK_ACCB_OFS 8'hf0
`define SFRBK_PDN_OFS 8'hf1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SFRBK_SUM_RST 8'h00
`define SFRBK_TRIM_RST 8'h00
`define SFRBK_SMON_RST 8'h00
`define SFRBK_IEN_RST 8'he0
`define SFRBK_FTIM_RST 8'ha5
`define SFRBK_ACCB_RST 8'h00
`define SFRBK_PDN_RST 8'h7f
`define SFRBK_MS_DIV_RST 16'h0f9f
`define SFRBK_US_DIV_RST 6'h03

// ----------------------------------------
// Field positions and fixed patterns
// ----------------------------------------
`define SFRBK_IEN_FIXED 8'he0
`define SFRBK_TRIM_NEG_ZERO 8'h80
// Upper six product code bits; arbitrary value
`define SFRBK_PCL_FIXED 6'h2d
`define SFRBK_FCTL_PAGE_ERASE_BIT 6
`define SFRBK_FCTL_DLY_BIT 4
`define SFRBK_FCTL_BUSY_BIT 2
`define SFRBK_FCTL_SERIAL_BIT 1
`define SFRBK_FCTL_PROG_BIT 0
`define SFRBK_WRITE_MULT 5

`endif

// ### hdl/sfrbk_divider.sv
// Clearable divider producing a one-cycle tick every (div+1) clocks.
// Assumes div is stable for the length of a flash pulse.
`timescale 1ns/1ps
module sfrbk_divider #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic [WIDTH-1:0] div,
  output logic tick
);
  initial begin
    if (WIDTH < 1) $error("sfrbk_divider: WIDTH too small");
  end

  logic [WIDTH-1:0] cnt_reg;

  // Count up to div, then wrap and pulse
  always_ff @(posedge sys_clk) begin
    if (srst || clear) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= div) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = !srst && !clear && (cnt_reg >= div);
endmodule : sfrbk_divider

// ### hdl/sfrbk_pkg.sv
// Types shared by the SFR slice.
// Assumes the defines header is included by the users.
package sfrbk_pkg;

  // Decoded supply monitor control
  typedef struct packed {
    logic analog_enable;
    logic [2:0] analog_threshold_sel;
    logic analog_use_input_seven;
    logic digital_enable;
    logic [2:0] digital_threshold_sel;
    logic digital_use_input_six;
  } sfrbk_supply_t;

  // Peripheral power-down lines
  typedef struct packed {
    logic dac_power_down;
    logic twowire_power_down;
    logic pulse_width_power_down;
    logic converter_power_down;
    logic watchdog_power_down;
    logic system_timer_power_down;
    logic spi_power_down;
  } sfrbk_power_t;

  // Flash timer states, Gray along idle-run-done
  typedef enum logic [1:0] {
    SFRBK_FL_IDLE = 2'b00,
    SFRBK_FL_RUN = 2'b01,
    SFRBK_FL_DONE = 2'b11
  } sfrbk_fl_state_t;

endpackage : sfrbk_pkg

// ### sim/tb_sfrbk_bank.sv
// Self-checking bench for the SFR slice: drives the SFR bus and side inputs,
// compares reads and outputs with values reckoned from the register map.
// Assumes the design package and the defines header are compiled first.
`timescale 1ns/1ps
module tb_sfrbk_bank import sfrbk_pkg::*; ;
  // ----------------------------------------
  // Signals and design instance
  // ----------------------------------------
  localparam logic [15:0] MSD = 16'h0003; // Short dividers keep pulses brief
  localparam logic [5:0] USD = 6'h01;
  logic sys_clk, srst, sfr_wr, sfr_rd, sum_load, watchdog_irq_req, watchdog_irq;
  logic flash_erase_start, flash_write_start, prog_mode_in, serial_prog_in;
  logic offset_enable, offset_negative, page_erase_mode, flash_delay_line_sel;
  logic flash_pulse, flash_busy;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, secondary_accumulator;
  logic [15:0] sum_upper_in, sum_upper;
  logic [3:0] ext_irq_req, ext_irq;
  logic [6:0] offset_magnitude;
  sfrbk_supply_t supply_ctrl;
  sfrbk_power_t power_ctrl;
  int n_fail, n_tests, cycles;

  sfrbk_bank u_sfrbk_bank (.sys_clk(sys_clk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .millisecond_divider(MSD), .microsecond_divider(USD),
    .flash_erase_start(flash_erase_start), .flash_write_start(flash_write_start),
    .prog_mode_in(prog_mode_in), .serial_prog_in(serial_prog_in), .sum_load(sum_load),
    .sum_upper_in(sum_upper_in), .sum_upper(sum_upper), .watchdog_irq_req(watchdog_irq_req),
    .ext_irq_req(ext_irq_req), .watchdog_irq(watchdog_irq), .ext_irq(ext_irq),
    .offset_enable(offset_enable), .offset_negative(offset_negative),
    .offset_magnitude(offset_magnitude), .supply_ctrl(supply_ctrl),
    .power_ctrl(power_ctrl), .page_erase_mode(page_erase_mode),
    .flash_delay_line_sel(flash_delay_line_sel), .flash_pulse(flash_pulse),
    .flash_busy(flash_busy), .secondary_accumulator(secondary_accumulator));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Strobe held for exactly one sampling edge, then released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  // Read data is registered at the read edge, so it is taken just after it
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    chk(what, {8'h00, sfr_rdata}, {8'h00, exp});
  endtask : rchk

  // Register effects reach the outputs two edges after the write
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] ra [13] = '{8'he4, 8'he5, 8'he6, 8'he7, 8'he8, 8'he9, 8'hea, 8'heb,
                            8'hee, 8'hef, 8'hf0, 8'hf1, 8'he0};
    logic [7:0] rv [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'hb7, 8'h5a, 8'h3c,
                            8'h00, 8'ha5, 8'h00, 8'h7f, 8'h00};
    for (int i = 0; i < 13; i++)
      rchk("reset value", ra[i], rv[i]);
    chk("power lines", {9'h000, power_ctrl}, 16'h007f);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_sum();
    wr(8'hf1, 8'h76); // Keeps the two-wire unit down while SPI runs
    settle();
    chk("power lines on", {9'h000, power_ctrl}, 16'h0076);
    wr(8'he4, 8'ha1);
    wr(8'he5, 8'hb2);
    rchk("sum byte2", 8'he4, 8'ha1);
    rchk("sum byte3", 8'he5, 8'hb2);
    chk("sum upper", sum_upper, 16'hb2a1);
    @(posedge sys_clk);
    sum_upper_in <= 16'h1234;
    sum_load <= 1'b1;
    @(posedge sys_clk);
    sum_load <= 1'b0;
    rchk("sum byte3 load", 8'he5, 8'h12);
    rchk("sum byte2 load", 8'he4, 8'h34);
    wr(8'hf1, 8'h7f);
    settle();
    chk("sum upper down", sum_upper, 16'h0000);
    rchk("sum byte2 down", 8'he4, 8'h00);
    chk("power lines", {9'h000, power_ctrl}, 16'h007f);
    $display("test summation done");
  endtask : t_sum

  task automatic t_trim();
    logic [7:0] tv [5] = '{8'h85, 8'h80, 8'h7f, 8'h00, 8'h01};
    for (int i = 0; i < 5; i++) begin
      wr(8'he6, tv[i]);
      settle();
      chk("offset", {7'h00, offset_enable, offset_negative, offset_magnitude},
          {7'h00, tv[i][6:0] != 7'h00, tv[i]});
      rchk("trim", 8'he6, tv[i]);
    end
    $display("test offset trim done");
  endtask : t_trim

  task automatic t_smon();
    logic [7:0] sv [5] = '{8'hf7, 8'h88, 8'h35, 8'h7f, 8'h00};
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      v = sv[i];
      wr(8'he7, v);
      settle();
      chk("supply", {6'h00, supply_ctrl}, {6'h00, ~v[7], v[6:4], v[6:4] == 3'h7,
          ~v[3], v[2:0], v[2:0] == 3'h7});
      rchk("monitor", 8'he7, v);
    end
    $display("test supply monitor done");
  endtask : t_smon

  task automatic t_irq();
    logic [7:0] ev [5] = '{8'h1f, 8'h0a, 8'h15, 8'h10, 8'h00};
    @(posedge sys_clk);
    watchdog_irq_req <= 1'b1;
    ext_irq_req <= 4'hf;
    settle();
    chk("irq masked", {11'h000, watchdog_irq, ext_irq}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(8'he8, ev[i]);
      settle();
      chk("irq gate", {11'h000, watchdog_irq, ext_irq}, {11'h000, ev[i][4:0]});
      rchk("irq enable", 8'he8, 8'he0 | ev[i]);
    end
    $display("test interrupt enable done");
  endtask : t_irq

  task automatic t_misc();
    wr(8'he9, 8'hff);
    wr(8'hea, 8'h00);
    wr(8'hf0, 8'hc3);
    rchk("product low", 8'he9, 8'hb7);
    rchk("product high", 8'hea, 8'h5a);
    rchk("operand", 8'hf0, 8'hc3);
    chk("operand out", {8'h00, secondary_accumulator}, 16'h00c3);
    $display("test read-only and operand done");
  endtask : t_misc

  task automatic t_fctl();
    @(posedge sys_clk);
    serial_prog_in <= 1'b1;
    wr(8'hee, 8'hff);
    settle();
    chk("flash modes", {14'h0000, page_erase_mode, flash_delay_line_sel}, 16'h0003);
    rchk("flash ctrl", 8'hee, 8'h50);
    @(posedge sys_clk);
    prog_mode_in <= 1'b1;
    serial_prog_in <= 1'b0;
    wr(8'hee, 8'h10);
    settle();
    chk("flash modes", {14'h0000, page_erase_mode, flash_delay_line_sel}, 16'h0001);
    rchk("flash ctrl", 8'hee, 8'h11);
    @(posedge sys_clk);
    serial_prog_in <= 1'b1;
    wr(8'hee, 8'h40);
    rchk("flash ctrl", 8'hee, 8'h43);
    wr(8'hee, 8'h00);
    prog_mode_in <= 1'b0;
    serial_prog_in <= 1'b0;
    settle();
    chk("flash modes", {14'h0000, page_erase_mode, flash_delay_line_sel}, 16'h0000);
    $display("test flash control done");
  endtask : t_fctl

  // A second start in mid-pulse must be ignored while the timer runs
  task automatic t_pulse(input logic [7:0] ft, input logic erase);
    int cnt;
    int exp;
    exp = erase ? (1 + ft[7:4]) * (1 + MSD) : (1 + ft[3:0]) * (1 + USD) * 5;
    cnt = 0;
    wr(8'hef, ft);
    @(posedge sys_clk);
    flash_erase_start <= erase;
    flash_write_start <= ~erase;
    @(posedge sys_clk);
    flash_erase_start <= 1'b0;
    flash_write_start <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      flash_erase_start <= (cnt == 3);
      #1;
      if (flash_pulse === 1'b1) begin
        cnt++;
        chk("busy", {15'h0000, flash_busy}, 16'h0001);
      end else if (cnt > 0)
        break;
    end
    chk("pulse length", cnt[15:0], exp[15:0]);
    settle();
    chk("idle", {15'h0000, flash_busy}, 16'h0000);
    rchk("flash ctrl idle", 8'hee, 8'h00);
    $display("test flash pulse done");
  endtask : t_pulse

  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Longest run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    {srst, sfr_wr, sfr_rd, sum_load, watchdog_irq_req, prog_mode_in, serial_prog_in} = 7'h40;
    {flash_erase_start, flash_write_start} = 2'b00;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sum_upper_in = 16'h0000;
    ext_irq_req = 4'h0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_sum();
    t_trim();
    t_smon();
    t_irq();
    t_misc();
    t_fctl();
    t_pulse(8'h21, 1'b1);
    t_pulse(8'h21, 1'b0);
    t_pulse(8'hfd, 1'b0);
    report_and_stop();
  end
endmodule : tb_sfrbk_bank
